// *** rtl/rtw_defines.svh ***
// Constants for the clock time and alarm value window block.
// Notes on behaviour
// R1: Minute tens digit sits in bits 14:12.
// R2: Minute units digit sits in bits 11:8.
// R3: Second tens digit sits in bits 6:4.
// R4: Second units digit sits in bits 3:0.
// R5: Alarm month tens bit 12, units 11:8.
// R6: Alarm date tens 5:4, units 3:0.
// R7: Alarm weekday index sits in bits 10:8.
// R8: Alarm hour tens 5:4, units 3:0.
// R9: Month/day and weekday/hour writes need unlock set.
// R10: Unimplemented bits always read as zero.
// R11: Alarm pointer 10, 01, 00 selects register.
// R12: Time pointer 00 shows time minutes/seconds.
// R13: Digit fields have no reset value.
// R14: Upper-half access steps alarm pointer down to 00.
// R15: Locked writes leave stored month/day and weekday/hour digits unchanged.
`ifndef RTW_DEFINES_SVH
`define RTW_DEFINES_SVH

`define RTW_ADDR_W           4
`define RTW_OFF_CTRL         4'h0
`define RTW_OFF_TIME_VALUE   4'h4
`define RTW_OFF_ALARM_VALUE  4'h8

`define RTW_CTRL_UNLOCK_BIT  0
`define RTW_CTRL_APTR_LSB    8
`define RTW_CTRL_APTR_MSB    9
`define RTW_CTRL_TPTR_LSB    16
`define RTW_CTRL_TPTR_MSB    17

`define RTW_PTR_MIN_SEC      2'h0
`define RTW_PTR_WEEKDAY_INDEX_HOUR    2'h1
`define RTW_PTR_MONTH_DAY    2'h2

`define RTW_RST_UNLOCK       1'h0
`define RTW_RST_PTR          2'h0

`define RTW_RESP_OKAY        2'h0
`define RTW_RESP_SLVERR      2'h2

`endif

// *** rtl/rtw_pkg.sv ***
// Types shared by the clock time and alarm value window block.
package rtw_pkg;

  typedef struct packed {
    logic       pad_hi;
    logic [2:0] minute_tens;
    logic [3:0] minute_units;
    logic       pad_lo;
    logic [2:0] second_tens;
    logic [3:0] second_units;
  } rtw_min_sec_s;

  typedef struct packed {
    logic [2:0] pad_hi;
    logic       month_tens_bit;
    logic [3:0] month_units;
    logic [1:0] pad_lo;
    logic [1:0] date_tens;
    logic [3:0] date_units;
  } rtw_month_day_s;

  typedef struct packed {
    logic [4:0] pad_hi;
    logic [2:0] weekday_index;
    logic [1:0] pad_lo;
    logic [1:0] hour_tens;
    logic [3:0] hour_units;
  } rtw_weekday_index_hour_s;

  typedef enum logic [0:0] {
    RTW_WR_COLLECT,
    RTW_WR_RESPOND
  } rtw_wr_state_e;

endpackage

// *** rtl/rtw_top.sv ***
// Clock time and alarm value window registers behind an AXI4-Lite slave.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "rtw_defines.svh"

module rtw_top (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address channel.
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data channel.
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data channel.
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Links to the rest of the clock.
  output logic [1:0]       time_window_pointer,
  output logic [1:0]       alarm_window_pointer,
  output logic             clock_write_unlock,
  output logic             alarm_match
);

  // Bus side state.
  rtw_pkg::rtw_wr_state_e    wr_state_reg;
  logic                      aw_held_reg;
  logic                      w_held_reg;
  logic [`RTW_ADDR_W-1:0]    aw_addr_reg;
  logic [31:0]               w_data_reg;
  logic [3:0]                w_strb_reg;
  logic [1:0]                bresp_reg;
  logic                      rvalid_reg;
  logic [31:0]               rdata_reg;
  logic [1:0]                rresp_reg;

  // Control state.
  logic                      unlock_reg;
  logic [1:0]                tptr_reg;
  logic [1:0]                aptr_reg;
  logic [1:0]                aptr_next;
  logic                      match_reg;

  // Digit storage, deliberately left without reset.
  rtw_pkg::rtw_min_sec_s     time_ms_reg;
  rtw_pkg::rtw_min_sec_s     alarm_ms_reg;
  rtw_pkg::rtw_month_day_s   alarm_md_reg;
  rtw_pkg::rtw_weekday_index_hour_s   alarm_wh_reg;

  // Decoded bus events.
  logic                      wr_fire;
  logic                      rd_fire;
  logic                      wr_ctrl;
  logic                      wr_time;
  logic                      wr_alarm;
  logic                      wr_alarm_upper;
  logic                      rd_alarm;
  logic                      rd_hit;
  logic                      wr_hit;
  logic [15:0]               wdata16;
  logic [15:0]               lane_mask;
  logic [15:0]               alarm_view;
  logic [15:0]               time_view;
  logic [31:0]               ctrl_view;
  logic [31:0]               rd_word;
  logic [`RTW_ADDR_W-1:0]    rd_addr;

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = (wr_state_reg == rtw_pkg::RTW_WR_COLLECT) &&
                         !aw_held_reg;
  assign s_axi_wready  = (wr_state_reg == rtw_pkg::RTW_WR_COLLECT) &&
                         !w_held_reg;
  assign s_axi_bvalid  = (wr_state_reg == rtw_pkg::RTW_WR_RESPOND);
  assign s_axi_bresp   = bresp_reg;

  assign wr_fire = (wr_state_reg == rtw_pkg::RTW_WR_COLLECT) &&
                   aw_held_reg && w_held_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr[`RTW_ADDR_W-1:0] & 4'hc;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Addresses above the decoded range are unmapped.
  assign wr_hit = (s_axi_awaddr_hi_zero_w(aw_addr_reg)) &&
                  (aw_addr_reg == `RTW_OFF_CTRL ||
                   aw_addr_reg == `RTW_OFF_TIME_VALUE ||
                   aw_addr_reg == `RTW_OFF_ALARM_VALUE);

  function automatic logic s_axi_awaddr_hi_zero_w(
    input logic [`RTW_ADDR_W-1:0] a
  );
    s_axi_awaddr_hi_zero_w = (a[1:0] == 2'h0);
  endfunction

  logic awaddr_hi_ok_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_hi_ok_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awaddr_hi_ok_reg <= (s_axi_awaddr[31:`RTW_ADDR_W] == '0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= rtw_pkg::RTW_WR_COLLECT;
      bresp_reg    <= `RTW_RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        rtw_pkg::RTW_WR_COLLECT: begin
          if (wr_fire) begin
            wr_state_reg <= rtw_pkg::RTW_WR_RESPOND;
            bresp_reg    <= (wr_hit && awaddr_hi_ok_reg) ?
                            `RTW_RESP_OKAY : `RTW_RESP_SLVERR;
          end
        end
        rtw_pkg::RTW_WR_RESPOND: begin
          if (s_axi_bready) begin
            wr_state_reg <= rtw_pkg::RTW_WR_COLLECT;
          end
        end
      endcase
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit value windows.
  assign lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wdata16   = w_data_reg[15:0];

  assign wr_ctrl  = wr_fire && awaddr_hi_ok_reg &&
                    aw_addr_reg == `RTW_OFF_CTRL;
  assign wr_time  = wr_fire && awaddr_hi_ok_reg &&
                    aw_addr_reg == `RTW_OFF_TIME_VALUE;
  assign wr_alarm = wr_fire && awaddr_hi_ok_reg &&
                    aw_addr_reg == `RTW_OFF_ALARM_VALUE;
  assign wr_alarm_upper = wr_alarm && w_strb_reg[1];

  // Control register: unlock bit and both window pointers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_reg <= `RTW_RST_UNLOCK;
      tptr_reg   <= `RTW_RST_PTR;
    end else if (wr_ctrl) begin
      if (w_strb_reg[0]) begin
        unlock_reg <= w_data_reg[`RTW_CTRL_UNLOCK_BIT];
      end
      if (w_strb_reg[2]) begin
        tptr_reg <= w_data_reg[`RTW_CTRL_TPTR_MSB:`RTW_CTRL_TPTR_LSB];
      end
    end
  end

  // A pointer write wins over the step caused by a window access.
  always_comb begin
    aptr_next = aptr_reg;
    if (wr_ctrl && w_strb_reg[1]) begin
      aptr_next = w_data_reg[`RTW_CTRL_APTR_MSB:`RTW_CTRL_APTR_LSB];
    end else if ((wr_alarm_upper || rd_alarm) &&
                 aptr_reg != `RTW_PTR_MIN_SEC) begin
      aptr_next = aptr_reg - 2'h1; // [R14]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aptr_reg <= `RTW_RST_PTR;
    end else begin
      aptr_reg <= aptr_next;
    end
  end

  // Time minutes/seconds register, writable at pointer 00.
  always_ff @(posedge aclk) begin
    if (wr_time && tptr_reg == `RTW_PTR_MIN_SEC) begin // [R12]
      time_ms_reg <= (time_ms_reg & ~lane_mask) |
                     (wdata16 & lane_mask & 16'h7f7f); // [R1] [R2] [R3] [R4] [R13]
    end
  end

  // Alarm registers, selected by the alarm pointer.
  always_ff @(posedge aclk) begin
    if (wr_alarm && aptr_reg == `RTW_PTR_MIN_SEC) begin // [R11]
      alarm_ms_reg <= (alarm_ms_reg & ~lane_mask) |
                      (wdata16 & lane_mask & 16'h7f7f); // [R13]
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_alarm && unlock_reg &&
        aptr_reg == `RTW_PTR_MONTH_DAY) begin // [R9] [R11] [R15]
      alarm_md_reg <= (alarm_md_reg & ~lane_mask) |
                      (wdata16 & lane_mask & 16'h1f3f); // [R5] [R6] [R13]
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_alarm && unlock_reg &&
        aptr_reg == `RTW_PTR_WEEKDAY_INDEX_HOUR) begin // [R9] [R11] [R15]
      alarm_wh_reg <= (alarm_wh_reg & ~lane_mask) |
                      (wdata16 & lane_mask & 16'h073f); // [R7] [R8] [R13]
    end
  end

  // Read views with unimplemented bits forced to zero.
  always_comb begin
    unique case (aptr_reg) // [R11]
      `RTW_PTR_MIN_SEC:   alarm_view = alarm_ms_reg & 16'h7f7f; // [R10]
      `RTW_PTR_WEEKDAY_INDEX_HOUR: alarm_view = alarm_wh_reg & 16'h073f; // [R10]
      `RTW_PTR_MONTH_DAY: alarm_view = alarm_md_reg & 16'h1f3f; // [R10]
      default:            alarm_view = 16'h0000; // [R10]
    endcase
  end

  assign time_view = (tptr_reg == `RTW_PTR_MIN_SEC) ?
                     (time_ms_reg & 16'h7f7f) : 16'h0000; // [R10] [R12]

  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[`RTW_CTRL_UNLOCK_BIT] = unlock_reg;
    ctrl_view[`RTW_CTRL_APTR_MSB:`RTW_CTRL_APTR_LSB] = aptr_reg;
    ctrl_view[`RTW_CTRL_TPTR_MSB:`RTW_CTRL_TPTR_LSB] = tptr_reg;
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = s_axi_araddr[`RTW_ADDR_W-1:0];
  assign rd_hit        = (s_axi_araddr[31:`RTW_ADDR_W] == '0) &&
                         (rd_addr == `RTW_OFF_CTRL ||
                          rd_addr == `RTW_OFF_TIME_VALUE ||
                          rd_addr == `RTW_OFF_ALARM_VALUE);
  assign rd_alarm      = rd_fire && rd_hit &&
                         rd_addr == `RTW_OFF_ALARM_VALUE; // [R14]

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_hit) begin
      if (rd_addr == `RTW_OFF_CTRL) begin
        rd_word = ctrl_view;
      end else if (rd_addr == `RTW_OFF_TIME_VALUE) begin
        rd_word = {16'h0000, time_view};
      end else begin
        rd_word = {16'h0000, alarm_view};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RTW_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `RTW_RESP_OKAY : `RTW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Alarm compare on minutes and seconds, registered for the clock core.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= ((time_ms_reg & 16'h7f7f) ==
                    (alarm_ms_reg & 16'h7f7f));
    end
  end

  assign time_window_pointer  = tptr_reg;
  assign alarm_window_pointer = aptr_reg;
  assign clock_write_unlock   = unlock_reg;
  assign alarm_match          = match_reg;

endmodule

// *** sim/rtw_top_props.sv ***
// Assertions on the bus handshakes and window pointers of the window block.
`timescale 1ns/10ps
`include "rtw_defines.svh"
module rtw_top_props (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  // Links to the rest of the clock.
  input wire logic [1:0]  time_window_pointer,
  input wire logic [1:0]  alarm_window_pointer,
  input wire logic        clock_write_unlock
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ar_alarm;
  assign ar_alarm = s_axi_arvalid && s_axi_arready &&
                    s_axi_araddr == {28'h0, `RTW_OFF_ALARM_VALUE};
  property p_pad_zero;
    s_axi_rvalid |-> s_axi_rdata[31:18] == 14'h0 &&
                     !s_axi_rdata[15] && !s_axi_rdata[7];
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("unused read bits not zero");
  property p_ptr_step;
    ar_alarm && alarm_window_pointer != 2'h0 |=>
      alarm_window_pointer == $past(alarm_window_pointer) - 2'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("alarm pointer did not step down");
  property p_ptr_floor;
    ar_alarm && alarm_window_pointer == 2'h0 |=> alarm_window_pointer == 2'h0;
  endproperty
  a_ptr_floor: assert property (p_ptr_floor)
    else $error("alarm pointer left zero");
  property p_empty_slot;
    ar_alarm && alarm_window_pointer == 2'h3 |=> s_axi_rdata == 32'h0;
  endproperty
  a_empty_slot: assert property (p_empty_slot)
    else $error("empty alarm slot read nonzero");
  property p_unlock_write;
    !$stable(clock_write_unlock) |-> $rose(s_axi_bvalid);
  endproperty
  a_unlock_write: assert property (p_unlock_write)
    else $error("unlock bit changed without a write");
  property p_tptr_write;
    !$stable(time_window_pointer) |-> $rose(s_axi_bvalid);
  endproperty
  a_tptr_write: assert property (p_tptr_write)
    else $error("time pointer changed without a write");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer not two cycles after");
  property p_rd_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_block: assert property (p_rd_block)
    else $error("read address taken while answer pending");
  c_step: cover property (ar_alarm && alarm_window_pointer == 2'h2);
  c_unlock: cover property ($rose(clock_write_unlock));
  c_write: cover property ($rose(s_axi_bvalid));
endmodule
bind rtw_top rtw_top_props i_rtw_top_props (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .s_axi_awvalid        (s_axi_awvalid),
  .s_axi_awready        (s_axi_awready),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_wready         (s_axi_wready),
  .s_axi_bvalid         (s_axi_bvalid),
  .s_axi_arvalid        (s_axi_arvalid),
  .s_axi_arready        (s_axi_arready),
  .s_axi_rvalid         (s_axi_rvalid),
  .s_axi_araddr         (s_axi_araddr),
  .s_axi_rdata          (s_axi_rdata),
  .time_window_pointer  (time_window_pointer),
  .alarm_window_pointer (alarm_window_pointer),
  .clock_write_unlock   (clock_write_unlock)
);

// *** sim/rtw_top_tb_top.sv ***
// Self-checking bench for the clock time and alarm value window block.
`timescale 1ns/10ps
`include "rtw_defines.svh"
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rtw_top_tb_top;
  logic        aclk, aresetn, alarm_match, clock_write_unlock;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [1:0]  time_window_pointer, alarm_window_pointer;
  int          error_cnt, tests_run, cycles;
  localparam logic [31:0] CTRL = {28'h0, `RTW_OFF_CTRL};
  localparam logic [31:0] TVAL = {28'h0, `RTW_OFF_TIME_VALUE};
  localparam logic [31:0] AVAL = {28'h0, `RTW_OFF_ALARM_VALUE};
  localparam logic [15:0] MSK [3] = '{16'h1f3f, 16'h073f, 16'h7f7f};
  localparam logic [15:0] VAL [3] = '{16'h1231, 16'h0623, 16'h4530};
  rtw_top i_rtw_top (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    int j;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} <= 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= 96'h0;
    {s_axi_awprot, s_axi_arprot} <= 6'h0;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL);
    `CK(rdat, 32'h0)
    wr(CTRL, 32'hffff_ffff, 4'hf);
    `CK({time_window_pointer, alarm_window_pointer, clock_write_unlock}, 5'h1f)
    rd(CTRL);
    `CK(rdat, 32'h0003_0301)
    rd(TVAL);
    `CK(rdat, 32'h0)
    wr(CTRL, 32'h0, 4'hf);
    `CK(time_window_pointer, `RTW_PTR_MIN_SEC)
    wr(TVAL, 32'hffff_ffff, 4'hf);
    rd(TVAL);
    `CK(rdat, 32'h7f7f)
    wr(TVAL, 32'h5939, 4'h3);
    rd(TVAL);
    `CK(rdat, 32'h5939)
    // First pass fills every bit to see the field masks, second stores digits.
    for (int p = 0; p < 2; p++) begin
      wr(CTRL, 32'h0201, 4'h3);
      `CK(clock_write_unlock, 1'b1)
      for (int i = 0; i < 3; i++) begin
        wr(AVAL, {16'h0, p ? VAL[i] : 16'hffff}, 4'h3);
        `CK(alarm_window_pointer, (i == 0) ? 2'h1 : 2'h0)
      end
      wr(CTRL, 32'h0201, 4'h3);
      for (int i = 0; i < 4; i++) begin
        j = (i < 3) ? i : 2;
        rd(AVAL);
        `CK(rdat, {16'h0, p ? VAL[j] : MSK[j]})
      end
    end
    wr(CTRL, 32'h0300, 4'h3);
    rd(AVAL);
    `CK(rdat, 32'h0)
    `CK(alarm_window_pointer, `RTW_PTR_MONTH_DAY)
    for (int i = 0; i < 3; i++) begin
      wr(AVAL, 32'h0, 4'h3);
      `CK(resp, `RTW_RESP_OKAY)
    end
    wr(CTRL, 32'h0200, 4'h3);
    for (int i = 0; i < 3; i++) begin
      rd(AVAL);
      `CK(rdat[15:0], (i < 2) ? VAL[i] : 16'h0)
    end
    rd(32'hc);
    `CK({resp, rdat}, {`RTW_RESP_SLVERR, 32'h0})
    wr(32'hc, 32'hffff, 4'hf);
    `CK(resp, `RTW_RESP_SLVERR)
    // A time window write away from pointer 00 must be dropped.
    wr(CTRL, 32'h0001_0000, 4'h4);
    `CK(time_window_pointer, 2'h1)
    wr(TVAL, 32'h0, 4'h3);
    rd(TVAL);
    `CK(rdat, 32'h0)
    wr(CTRL, 32'h0, 4'h4);
    rd(TVAL);
    `CK(rdat, 32'h5939)
    // The match output follows the stored digits one cycle late.
    `CK(alarm_match, 1'b0)
    wr(AVAL, 32'h5939, 4'h3);
    @(posedge aclk);
    `CK(alarm_match, 1'b1)
    finish_test();
  end
endmodule
